// File: include/partition_id_ctrl_params.svh
`ifndef PARTITION_ID_CTRL_PARAMS_SVH
`define PARTITION_ID_CTRL_PARAMS_SVH

// System-register encoding fields of the registers of this block; only op0 and CRn are shared by every register.
`define OP0_SYSREG 2'h3
`define OP1_HYP 3'h4
`define OP1_EL3 3'h6
`define OP1_EL1 3'h0
`define OP1_ALIAS 3'h5
`define CRN_PARTITION 4'hA
`define CRM_MAP_ENTRY 4'h6
`define OP2_MAP_ENTRY_28_31 3'h7
`define CRM_MAP_VALID 4'h4
`define OP2_MAP_VALID 3'h1
`define CRM_CTRL 4'h5
`define OP2_CTRL 3'h0
`define CRM_HYP_CTRL 4'h4
`define OP2_HYP_CTRL 3'h0

// Exception levels.
`define EL0 2'h0
`define EL1 2'h1
`define EL2 2'h2
`define EL3 2'h3

// Nested save memory offsets and the trap syndrome.
`define NESTED_SAVE_MEMORY_MAP_ENTRY_28_31 12'h978
`define NESTED_SAVE_MEMORY_MAP_VALID 12'h938
`define SYNDROME_SYSREG 6'h18

// Field positions inside the 64-bit control registers.
`define BIT_PART_ENABLE 63
`define BIT_LOWER_TRAP 62
`define BIT_TRAP_KERNEL 48
`define BIT_TRAP_USER 49
`define BIT_USER_VPM 0
`define BIT_KERNEL_VPM 1
`define BIT_GUEST_LOCK 8
`define BIT_TRAP_IDENT 31

// Mapping store geometry and default identifiers.
`define VALID_BITS 32
`define ENTRY_COUNT 4
`define ENTRY_GROUP 3'h7
`define DEFAULT_PARTITION_ID 16'h0000
`define DEFAULT_PMG 8'h00

`endif

// File: include/partition_id_ctrl_pkg.sv
`include "partition_id_ctrl_params.svh"

package partition_id_ctrl_pkg;

  typedef enum logic [2:0] {
    SEL_NONE,
    SEL_MAP_ENTRY,
    SEL_MAP_VALID,
    SEL_EL3_CTRL,
    SEL_EL2_CTRL,
    SEL_EL1_CTRL,
    SEL_EL1_ALIAS,
    SEL_HYP_CTRL
  } reg_sel_t;

  typedef enum logic [2:0] {
    OUT_NONE,
    OUT_ACCESS,
    OUT_RAZ_WI,
    OUT_UNDEF,
    OUT_TRAP,
    OUT_NESTED_SAVE_MEMORY
  } outcome_t;

  typedef struct packed {
    logic valid;
    logic write;
    logic [1:0] el;
    logic secure;
    logic [1:0] op0;
    logic [2:0] op1;
    logic [3:0] crn;
    logic [3:0] crm;
    logic [2:0] op2;
    logic [63:0] wdata;
  } sysreg_req_t;

  typedef struct packed {
    logic part_impl;
    logic hyp_ctrl_present;
    logic have_el3;
    logic have_el2_ns;
    logic have_el2_s;
    logic secure_hyp_enable;
    logic nested_virt_ctrl;
    logic enhanced_nested_virt_ctrl;
    logic host_extension;
  } core_cfg_t;

  typedef struct packed {
    outcome_t outcome;
    logic [1:0] trap_el;
    logic [11:0] nested_save_memory_offset;
  } route_t;

  typedef struct packed {
    logic valid;
    logic hit;
    logic undef;
    logic trap;
    logic [1:0] trap_el;
    logic [5:0] syndrome;
    logic nested_save_memory;
    logic nested_save_memory_write;
    logic [11:0] nested_save_memory_offset;
    logic [63:0] rdata;
  } sysreg_resp_t;

  typedef struct packed {
    logic valid;
    logic secure;
    logic user;
    logic virt;
    logic [15:0] partition_id;
    logic [7:0] monitor_group;
  } id_req_t;

  typedef struct packed {
    logic valid;
    logic [15:0] partition_id;
    logic [7:0] monitor_group;
    logic nonsecure_id_space;
  } id_out_t;

endpackage

// File: rtl/map_entry_store.sv
`timescale 1ns/100ps
`include "partition_id_ctrl_params.svh"

module map_entry_store (
  // Clock
  input wire logic clock_in,
  // Write side
  input wire logic wr_entry_in,
  input wire logic wr_valid_in,
  input wire logic [63:0] wdata_in,
  // Lookup
  input wire logic [4:0] lookup_vid_in,
  // Stored words and lookup result
  output logic [63:0] entry_word_out,
  output logic [`VALID_BITS-1:0] valid_word_out,
  output logic lookup_hit_out,
  output logic [15:0] lookup_partition_id_out
);
  // Contents come out of reset unknown, so no reset is applied here.
  logic [`VALID_BITS-1:0] valid_r;
  logic [`VALID_BITS-1:0] valid_nxt;
  logic [15:0] entry_r [`ENTRY_COUNT];

  genvar g;
  generate
    for (g = 0; g < `ENTRY_COUNT; g++) begin : g_entry
      logic [15:0] entry_nxt;
      always_comb begin
        entry_nxt = wr_entry_in ? wdata_in[16*g +: 16] : entry_r[g];
      end
      always_ff @(posedge clock_in) begin
        entry_r[g] <= entry_nxt;
      end
      assign entry_word_out[16*g +: 16] = entry_r[g];
    end
  endgenerate

  always_comb begin
    valid_nxt = wr_valid_in ? wdata_in[`VALID_BITS-1:0] : valid_r;
  end

  always_ff @(posedge clock_in) begin
    valid_r <= valid_nxt;
  end

  assign valid_word_out = valid_r;
  // Entry index is the low two bits of the virtual id; only group 7 lives here.
  assign lookup_hit_out = (lookup_vid_in[4:2] == `ENTRY_GROUP) && valid_r[lookup_vid_in];
  assign lookup_partition_id_out = entry_r[lookup_vid_in[1:0]];
endmodule

// File: rtl/partition_id_map_valid_trap_ctrl.sv
`timescale 1ns/100ps
`include "partition_id_ctrl_params.svh"
module partition_id_map_valid_trap_ctrl (
  // Clock and reset
  input wire logic clock_in,
  input wire logic sys_rst_in,
  // System-register access from the core
  input partition_id_ctrl_pkg::sysreg_req_t req_in,
  input partition_id_ctrl_pkg::core_cfg_t cfg_in,
  output partition_id_ctrl_pkg::sysreg_resp_t resp_out,
  // Identifier generation
  input partition_id_ctrl_pkg::id_req_t id_req_in,
  output partition_id_ctrl_pkg::id_out_t id_out,
  // Control state
  output logic partition_enable_out,
  output logic lower_level_trap_out
);
  import partition_id_ctrl_pkg::*;

  reg_sel_t sel;
  route_t route;
  logic lower_trap_eff;
  logic trap_kernel_eff;
  logic [63:0] entry_word;
  logic [`VALID_BITS-1:0] valid_word;
  logic lookup_hit;
  logic [15:0] lookup_partition_id;
  logic wr_entry;
  logic wr_valid;
  logic do_write;
  logic id_el2_en;
  logic map_on;
  logic el2_any;

  logic pe_r;
  logic pe_nxt;
  logic llt_r;
  logic llt_nxt;
  logic rst_pend_r;
  logic rst_pend_nxt;
  logic tgk_r;
  logic tgk_nxt;
  logic tgu_r;
  logic tgu_nxt;
  logic tid_r;
  logic tid_nxt;
  logic gal_r;
  logic gal_nxt;
  logic kvpm_r;
  logic kvpm_nxt;
  logic uvpm_r;
  logic uvpm_nxt;
  sysreg_resp_t resp_r;
  sysreg_resp_t resp_nxt;
  id_out_t id_r;
  id_out_t id_nxt;
  logic [63:0] rdata;
  logic wr_entry_past_q;

  // Without EL3 the lower-level trap behaves as zero, but lower_level_trap_out stays one until the first clock edge after reset.
  assign lower_trap_eff = cfg_in.have_el3 && llt_r;
  assign trap_kernel_eff = tgk_r;
  assign el2_any = cfg_in.have_el2_ns || cfg_in.have_el2_s;

  sysreg_access_route u_route (
    .req_in(req_in),
    .cfg_in(cfg_in),
    .lower_trap_in(lower_trap_eff),
    .trap_kernel_in(trap_kernel_eff),
    .sel_out(sel),
    .route_out(route)
  );

  assign do_write = req_in.write && (route.outcome == OUT_ACCESS);
  assign wr_entry = do_write && (sel == SEL_MAP_ENTRY);
  assign wr_valid = do_write && (sel == SEL_MAP_VALID);

  map_entry_store u_store (
    .clock_in(clock_in),
    .wr_entry_in(wr_entry),
    .wr_valid_in(wr_valid),
    .wdata_in(req_in.wdata),
    .lookup_vid_in(id_req_in.partition_id[4:0]),
    .entry_word_out(entry_word),
    .valid_word_out(valid_word),
    .lookup_hit_out(lookup_hit),
    .lookup_partition_id_out(lookup_partition_id)
  );

  // Control register updates; the enable bit is writable only at the highest level.
  always_comb begin
    pe_nxt = pe_r;
    llt_nxt = llt_r;
    tgk_nxt = tgk_r;
    tgu_nxt = tgu_r;
    tid_nxt = tid_r;
    gal_nxt = gal_r;
    kvpm_nxt = kvpm_r;
    uvpm_nxt = uvpm_r;
    rst_pend_nxt = 1'b0;
    if (rst_pend_r && !cfg_in.have_el3) begin
      tgk_nxt = 1'b1;
      tgu_nxt = 1'b1;
      tid_nxt = 1'b1;
    end else if (do_write) begin
      if (sel == SEL_EL3_CTRL) begin
        pe_nxt = req_in.wdata[`BIT_PART_ENABLE];
        llt_nxt = req_in.wdata[`BIT_LOWER_TRAP];
      end else if (sel == SEL_EL2_CTRL) begin
        if (!cfg_in.have_el3) begin
          pe_nxt = req_in.wdata[`BIT_PART_ENABLE];
        end
        tgk_nxt = req_in.wdata[`BIT_TRAP_KERNEL];
        tgu_nxt = req_in.wdata[`BIT_TRAP_USER];
      end else if (sel == SEL_EL1_CTRL || sel == SEL_EL1_ALIAS) begin
        if (!cfg_in.have_el3 && !el2_any) begin
          pe_nxt = req_in.wdata[`BIT_PART_ENABLE];
        end
      end else if (sel == SEL_HYP_CTRL) begin
        tid_nxt = req_in.wdata[`BIT_TRAP_IDENT];
        gal_nxt = req_in.wdata[`BIT_GUEST_LOCK];
        kvpm_nxt = req_in.wdata[`BIT_KERNEL_VPM];
        uvpm_nxt = req_in.wdata[`BIT_USER_VPM];
      end
    end
  end

  always_ff @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      pe_r <= 1'b0;
      llt_r <= 1'b1;
      rst_pend_r <= 1'b1;
      gal_r <= 1'b0;
      kvpm_r <= 1'b0;
      uvpm_r <= 1'b0;
    end else begin
      pe_r <= pe_nxt;
      llt_r <= llt_nxt;
      rst_pend_r <= rst_pend_nxt;
      gal_r <= gal_nxt;
      kvpm_r <= kvpm_nxt;
      uvpm_r <= uvpm_nxt;
    end
  end

  // These bits keep their value over reset when EL3 exists, so they carry no reset.
  always_ff @(posedge clock_in) begin
    tgk_r <= tgk_nxt;
    tgu_r <= tgu_nxt;
    tid_r <= tid_nxt;
  end

  // Read data; the EL1 control register and its alias only show a copy of the enable bit.
  always_comb begin
    rdata = 64'h0000_0000_0000_0000;
    if (route.outcome == OUT_ACCESS) begin
      if (sel == SEL_MAP_ENTRY) begin
        rdata = entry_word;
      end else if (sel == SEL_MAP_VALID) begin
        rdata[`VALID_BITS-1:0] = valid_word;
      end else if (sel == SEL_EL3_CTRL) begin
        rdata[`BIT_PART_ENABLE] = pe_r;
        rdata[`BIT_LOWER_TRAP] = llt_r;
      end else if (sel == SEL_EL2_CTRL) begin
        rdata[`BIT_PART_ENABLE] = pe_r;
        rdata[`BIT_TRAP_KERNEL] = tgk_r;
        rdata[`BIT_TRAP_USER] = tgu_r;
      end else if (sel == SEL_EL1_CTRL || sel == SEL_EL1_ALIAS) begin
        rdata[`BIT_PART_ENABLE] = pe_r;
      end else if (sel == SEL_HYP_CTRL) begin
        rdata[`BIT_TRAP_IDENT] = tid_r;
        rdata[`BIT_GUEST_LOCK] = gal_r;
        rdata[`BIT_KERNEL_VPM] = kvpm_r;
        rdata[`BIT_USER_VPM] = uvpm_r;
      end
    end
  end

  always_comb begin
    resp_nxt = '0;
    resp_nxt.valid = req_in.valid;
    resp_nxt.hit = route.outcome != OUT_NONE;
    resp_nxt.undef = route.outcome == OUT_UNDEF;
    resp_nxt.trap = route.outcome == OUT_TRAP;
    resp_nxt.trap_el = route.trap_el;
    resp_nxt.syndrome = (route.outcome == OUT_TRAP) ? `SYNDROME_SYSREG : 6'h00;
    resp_nxt.nested_save_memory = route.outcome == OUT_NESTED_SAVE_MEMORY;
    resp_nxt.nested_save_memory_write = (route.outcome == OUT_NESTED_SAVE_MEMORY) && req_in.write;
    resp_nxt.nested_save_memory_offset = route.nested_save_memory_offset;
    resp_nxt.rdata = req_in.write ? 64'h0000_0000_0000_0000 : rdata;
  end

  // Identifier generation; mapping only applies where EL2 is enabled for the state.
  always_comb begin
    id_el2_en = id_req_in.secure ? (cfg_in.have_el2_s && cfg_in.secure_hyp_enable)
                                 : cfg_in.have_el2_ns;
    map_on = id_req_in.virt && id_el2_en && (id_req_in.user ? uvpm_r : kvpm_r);
    id_nxt.valid = id_req_in.valid;
    id_nxt.nonsecure_id_space = !id_req_in.secure;
    id_nxt.partition_id = `DEFAULT_PARTITION_ID;
    id_nxt.monitor_group = `DEFAULT_PMG;
    if (pe_r) begin
      id_nxt.monitor_group = id_req_in.monitor_group;
      if (!map_on) begin
        id_nxt.partition_id = id_req_in.partition_id;
      end else if (lookup_hit) begin
        id_nxt.partition_id = lookup_partition_id;
      end
    end
  end

  always_ff @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      resp_r <= '0;
      id_r <= '0;
    end else begin
      resp_r <= resp_nxt;
      id_r <= id_nxt;
    end
  end

  always_ff @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      partition_enable_out <= 1'b0;
      lower_level_trap_out <= 1'b1;
    end else begin
      partition_enable_out <= pe_nxt;
      lower_level_trap_out <= cfg_in.have_el3 && llt_nxt;
    end
  end

  assign resp_out = resp_r;
  assign id_out = id_r;

  el0_undef_a: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    (req_in.valid && sel != SEL_NONE && req_in.el == `EL0) |=> resp_out.undef)
    else $error("EL0 access was not undefined.");

  nested_save_memory_redirect_a: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    (req_in.valid && req_in.write && sel == SEL_MAP_ENTRY && req_in.el == `EL1
     && !req_in.secure && cfg_in.have_el2_ns && cfg_in.part_impl && cfg_in.hyp_ctrl_present
     && cfg_in.nested_virt_ctrl && cfg_in.enhanced_nested_virt_ctrl)
    |=> resp_out.nested_save_memory_write && resp_out.nested_save_memory_offset == `NESTED_SAVE_MEMORY_MAP_ENTRY_28_31)
    else $error("Nested write not redirected to save memory.");

  valid_nv_trap_a: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    (req_in.valid && sel == SEL_MAP_VALID && req_in.el == `EL1 && !req_in.secure
     && cfg_in.have_el2_ns && cfg_in.part_impl && cfg_in.hyp_ctrl_present
     && cfg_in.nested_virt_ctrl && !cfg_in.enhanced_nested_virt_ctrl)
    |=> resp_out.trap && resp_out.trap_el == `EL2 && resp_out.syndrome == `SYNDROME_SYSREG)
    else $error("Valid register nested access did not trap to EL2.");

  el2_lower_trap_a: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    (req_in.valid && sel == SEL_MAP_ENTRY && req_in.el == `EL2 && !req_in.secure
     && cfg_in.have_el2_ns && cfg_in.part_impl && cfg_in.hyp_ctrl_present
     && cfg_in.have_el3 && llt_r)
    |=> resp_out.trap && resp_out.trap_el == `EL3 && !wr_entry_past_q)
    else $error("EL2 entry access escaped the lower-level trap.");

  // Remembers whether the entries register was written on the previous edge.
  always_ff @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      wr_entry_past_q <= 1'b0;
    end else begin
      wr_entry_past_q <= wr_entry;
    end
  end

  reset_values_a: assert property (@(posedge clock_in)
    rst_pend_r |-> (!pe_r && llt_r && !partition_enable_out))
    else $error("Control bits wrong after reset.");

  default_ids_a: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    (id_req_in.valid && !pe_r) |=> (id_out.partition_id == `DEFAULT_PARTITION_ID
     && id_out.monitor_group == `DEFAULT_PMG
     && id_out.nonsecure_id_space == !$past(id_req_in.secure)))
    else $error("Default identifiers not emitted while disabled.");

  invalid_entry_a: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    (id_req_in.valid && pe_r && map_on && !lookup_hit)
    |=> id_out.partition_id == `DEFAULT_PARTITION_ID)
    else $error("Mapping entry used without its valid bit.");

  no_el3_undef_a: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    (req_in.valid && sel == SEL_EL3_CTRL && cfg_in.part_impl && !cfg_in.have_el3)
    |=> resp_out.undef)
    else $error("EL3 control register reachable without EL3.");

  raz_no_el2_a: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    (req_in.valid && !req_in.write && sel == SEL_MAP_VALID && req_in.el == `EL3
     && cfg_in.part_impl && cfg_in.hyp_ctrl_present && !cfg_in.have_el2_ns
     && !cfg_in.have_el2_s) |=> (!resp_out.undef && resp_out.rdata == 64'h0000_0000_0000_0000))
    else $error("Absent EL2 register did not read as zero from EL3.");

  valid_upper_zero_a: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    (req_in.valid && !req_in.write && sel == SEL_MAP_VALID && route.outcome == OUT_ACCESS)
    |=> resp_out.rdata[63:32] == 32'h0000_0000)
    else $error("Reserved valid register bits did not read as zero.");

  alias_undef_a: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    (req_in.valid && sel == SEL_EL1_ALIAS && req_in.el == `EL2 && cfg_in.part_impl
     && !cfg_in.host_extension) |=> resp_out.undef)
    else $error("Alias register reachable without host extension.");
endmodule

// File: rtl/sysreg_access_route.sv
`timescale 1ns/100ps
`include "partition_id_ctrl_params.svh"

module sysreg_access_route (
  // Access and configuration
  input partition_id_ctrl_pkg::sysreg_req_t req_in,
  input partition_id_ctrl_pkg::core_cfg_t cfg_in,
  input wire logic lower_trap_in,
  input wire logic trap_kernel_in,
  // Decode result
  output partition_id_ctrl_pkg::reg_sel_t sel_out,
  output partition_id_ctrl_pkg::route_t route_out
);
  import partition_id_ctrl_pkg::*;

  logic el2_en;
  logic no_el2;
  logic base;

  always_comb begin
    base = (req_in.op0 == `OP0_SYSREG) && (req_in.crn == `CRN_PARTITION);
    sel_out = SEL_NONE;
    if (base && req_in.op1 == `OP1_HYP && req_in.crm == `CRM_MAP_ENTRY
        && req_in.op2 == `OP2_MAP_ENTRY_28_31) begin
      sel_out = SEL_MAP_ENTRY;
    end else if (base && req_in.op1 == `OP1_HYP && req_in.crm == `CRM_MAP_VALID
        && req_in.op2 == `OP2_MAP_VALID) begin
      sel_out = SEL_MAP_VALID;
    end else if (base && req_in.op1 == `OP1_HYP && req_in.crm == `CRM_HYP_CTRL
        && req_in.op2 == `OP2_HYP_CTRL) begin
      sel_out = SEL_HYP_CTRL;
    end else if (base && req_in.crm == `CRM_CTRL && req_in.op2 == `OP2_CTRL) begin
      if (req_in.op1 == `OP1_EL3) begin
        sel_out = SEL_EL3_CTRL;
      end else if (req_in.op1 == `OP1_HYP) begin
        sel_out = SEL_EL2_CTRL;
      end else if (req_in.op1 == `OP1_EL1) begin
        sel_out = SEL_EL1_CTRL;
      end else if (req_in.op1 == `OP1_ALIAS) begin
        sel_out = SEL_EL1_ALIAS;
      end
    end
  end

  always_comb begin
    el2_en = req_in.secure ? (cfg_in.have_el2_s && cfg_in.secure_hyp_enable)
                           : cfg_in.have_el2_ns;
    no_el2 = !cfg_in.have_el2_ns && !(cfg_in.have_el2_s && cfg_in.secure_hyp_enable);
    route_out.outcome = OUT_NONE;
    route_out.trap_el = `EL0;
    route_out.nested_save_memory_offset = 12'h000;
    if (!req_in.valid || sel_out == SEL_NONE) begin
      route_out.outcome = OUT_NONE;
    end else if (!cfg_in.part_impl || ((sel_out == SEL_MAP_ENTRY || sel_out == SEL_MAP_VALID)
        && !cfg_in.hyp_ctrl_present)) begin
      route_out.outcome = OUT_UNDEF;
    end else if (req_in.el == `EL0) begin
      route_out.outcome = OUT_UNDEF;
    end else if (sel_out == SEL_EL3_CTRL) begin
      route_out.outcome = (cfg_in.have_el3 && req_in.el == `EL3) ? OUT_ACCESS : OUT_UNDEF;
    end else if (sel_out == SEL_EL1_CTRL) begin
      if (req_in.el != `EL3 && lower_trap_in) begin
        route_out.outcome = OUT_TRAP;
        route_out.trap_el = `EL3;
      end else if (req_in.el == `EL1 && trap_kernel_in && el2_en) begin
        route_out.outcome = OUT_TRAP;
        route_out.trap_el = `EL2;
      end else begin
        route_out.outcome = OUT_ACCESS;
      end
    end else if (req_in.el == `EL3) begin
      route_out.outcome = no_el2 ? OUT_RAZ_WI : OUT_ACCESS;
    end else if (no_el2) begin
      route_out.outcome = OUT_UNDEF;
    end else if (req_in.el == `EL1) begin
      if (el2_en && cfg_in.nested_virt_ctrl && cfg_in.enhanced_nested_virt_ctrl
          && (sel_out == SEL_MAP_ENTRY || sel_out == SEL_MAP_VALID)) begin
        route_out.outcome = OUT_NESTED_SAVE_MEMORY;
        route_out.nested_save_memory_offset = (sel_out == SEL_MAP_ENTRY) ? `NESTED_SAVE_MEMORY_MAP_ENTRY_28_31
                                                            : `NESTED_SAVE_MEMORY_MAP_VALID;
      end else if (el2_en && cfg_in.nested_virt_ctrl) begin
        route_out.outcome = OUT_TRAP;
        route_out.trap_el = (sel_out != SEL_MAP_VALID && lower_trap_in) ? `EL3 : `EL2;
      end else begin
        route_out.outcome = OUT_UNDEF;
      end
    end else if (!el2_en) begin
      route_out.outcome = OUT_UNDEF;
    end else if (sel_out == SEL_EL1_ALIAS && !cfg_in.host_extension) begin
      route_out.outcome = OUT_UNDEF;
    end else if (sel_out != SEL_MAP_VALID && lower_trap_in) begin
      route_out.outcome = OUT_TRAP;
      route_out.trap_el = `EL3;
    end else begin
      route_out.outcome = OUT_ACCESS;
    end
  end
endmodule

// File: testbench/partition_id_map_valid_trap_ctrl_tb.sv
`timescale 1ns/100ps
`include "partition_id_ctrl_params.svh"
module partition_id_map_valid_trap_ctrl_tb;
  import partition_id_ctrl_pkg::*;
  logic clock_in;
  logic sys_rst_in;
  sysreg_req_t req;
  core_cfg_t cfg;
  sysreg_resp_t resp;
  id_req_t idr;
  id_out_t ido;
  logic pen;
  logic ltrap;
  int err_count = 0;
  int check_count = 0;
  logic [63:0] ent;
  logic [63:0] vld;
  logic [15:0] p;
  logic vt;

  partition_id_map_valid_trap_ctrl DUT (.clock_in(clock_in), .sys_rst_in(sys_rst_in), .req_in(req),
    .cfg_in(cfg), .resp_out(resp), .id_req_in(idr), .id_out(ido),
    .partition_enable_out(pen), .lower_level_trap_out(ltrap));
  sysreg_issuer core (.clock_in(clock_in), .req_out(req), .resp_in(resp));

  initial begin
    clock_in = 1'b0;
    forever #2.5 clock_in = ~clock_in;
  end

  task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic close_out();
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // Kind: 0 direct, 1 undefined, 2 trap to EL2, 3 trap to EL3, 4 save memory.
  task automatic acc(input logic wr, input logic [1:0] el, input logic v, input logic [63:0] wd,
      input int kind, input logic [63:0] rd);
    logic tr;
    logic [11:0] off;
    tr = kind == 2 || kind == 3;
    off = kind != 4 ? 12'h000 : v ? `NESTED_SAVE_MEMORY_MAP_VALID : `NESTED_SAVE_MEMORY_MAP_ENTRY_28_31;
    core.access(wr, el, `OP1_HYP, v ? `CRM_MAP_VALID : `CRM_MAP_ENTRY,
      v ? `OP2_MAP_VALID : `OP2_MAP_ENTRY_28_31, wd);
    chk("resp flags", {38'h0, 2'h3, kind == 1, tr, tr ? 2'(kind) : 2'h0,
      tr ? `SYNDROME_SYSREG : 6'h00, kind == 4, kind == 4 && wr, off}, 64'(core.last_resp[89:64]));
    chk("resp rdata", rd, core.last_resp.rdata);
  endtask

  task automatic idq(input logic sec, input logic [25:0] exp);
    @(negedge clock_in);
    idr = {1'b1, sec, 1'($urandom), vt, p, exp[8:1]};
    @(negedge clock_in);
    chk("id result", 64'(exp), 64'(ido));
    idr.valid = 1'b0;
  endtask

  // Entries 0-27 live elsewhere, so a mapped id below 28 resolves to zero here.
  function automatic logic [15:0] exp_id(input logic [4:0] v);
    if (!vt) return p;
    if (v < 5'd28 || !vld[v]) return 16'h0000;
    return ent[16 * (v - 28) +: 16];
  endfunction

  initial begin
    #20000;
    err_count++;
    close_out();
  end

  initial begin
    void'($urandom(69));
    sys_rst_in = 1'b1;
    cfg = 9'h1E0;
    idr = '0;
    repeat (12) @(negedge clock_in);
    chk("trap in reset", 64'h1, 64'(ltrap));
    chk("enable in reset", 64'h0, 64'(pen));
    sys_rst_in = 1'b0;
    ent = {$urandom, $urandom};
    vld = {$urandom, $urandom};
    acc(1, `EL3, 0, ent, 0, 0);
    acc(0, `EL3, 0, 0, 0, ent);
    acc(1, `EL3, 1, vld, 0, 0);
    acc(0, `EL3, 1, 0, 0, {32'h0, vld[31:0]});
    acc(0, `EL0, 0, 0, 1, 0);
    acc(1, `EL0, 1, ~vld, 1, 0);
    acc(1, `EL2, 0, ~ent, 3, 0);
    acc(0, `EL2, 1, 0, 0, {32'h0, vld[31:0]});
    acc(0, `EL1, 0, 0, 1, 0);
    cfg.nested_virt_ctrl = 1'b1;
    acc(1, `EL1, 0, ~ent, 3, 0);
    acc(1, `EL1, 1, ~vld, 2, 0);
    cfg.enhanced_nested_virt_ctrl = 1'b1;
    acc(1, `EL1, 0, ~ent, 4, 0);
    acc(1, `EL1, 1, ~vld, 4, 0);
    cfg = 9'h1C0;
    acc(0, `EL3, 1, 0, 0, 0);
    cfg = 9'h1E0;
    acc(0, `EL3, 0, 0, 0, ent);
    core.access(0, `EL3, `OP1_HYP, `CRM_MAP_ENTRY, 3'h0, 0);
    chk("unknown reg", 64'(core.last_resp[89:64]), {38'h0, 1'b1, 25'h0});
    core.access(1, `EL3, `OP1_EL3, `CRM_CTRL, `OP2_CTRL, 64'h8000000000000000);
    chk("lower trap", 64'h0, 64'(ltrap));
    chk("enable", 64'h1, 64'(pen));
    ent = {$urandom, $urandom};
    acc(1, `EL2, 0, ent, 0, 0);
    acc(0, `EL2, 0, 0, 0, ent);
    core.access(1, `EL2, `OP1_HYP, `CRM_HYP_CTRL, `OP2_HYP_CTRL, 64'h3);
    for (int i = 0; i < 40; i++) begin
      vt = 1'($urandom);
      p = 16'(24 + $urandom_range(0, 7));
      idq(0, {1'b1, exp_id(p[4:0]), 8'($urandom), 1'b1});
    end
    core.access(1, `EL3, `OP1_EL3, `CRM_CTRL, `OP2_CTRL, 64'h0);
    for (int s = 0; s < 2; s++) begin
      p = 16'($urandom);
      idq(1'(s), {1'b1, 24'h0, s == 0});
    end
    close_out();
  end
endmodule

// File: testbench/sysreg_issuer.sv
`timescale 1ns/100ps
module sysreg_issuer (
  // Clock
  input wire logic clock_in,
  // Access path
  output partition_id_ctrl_pkg::sysreg_req_t req_out,
  input partition_id_ctrl_pkg::sysreg_resp_t resp_in
);
  import partition_id_ctrl_pkg::*;
  sysreg_resp_t last_resp;
  initial req_out = '0;
  // The response stands one cycle only, so it is captured at the very next falling edge.
  task automatic access(input logic wr, input logic [1:0] el, input logic [2:0] op1,
      input logic [3:0] crm, input logic [2:0] op2, input logic [63:0] wd);
    @(negedge clock_in);
    req_out = {1'b1, wr, el, 1'b0, 2'h3, op1, 4'hA, crm, op2, wd};
    @(negedge clock_in);
    last_resp = resp_in;
    req_out.valid = 1'b0;
    req_out.wdata = ~wd;
  endtask
endmodule
